// File: core/fcr_edge_sync.sv
// two-flop synchroniser and rising edge detector for every clock lane
// assumes each input toggles slower than half the system clock rate
`timescale 1ns/1ps
module fcr_edge_sync (
    input wire logic i_clock,
    input wire logic i_rst,
    fcr_edge_if.sync lanes
);
    logic [fcr_pkg::LANES-1:0] meta_reg;
    logic [fcr_pkg::LANES-1:0] sync_reg;
    logic [fcr_pkg::LANES-1:0] prev_reg;
    logic [fcr_pkg::LANES-1:0] rise_reg;
    logic [fcr_pkg::LANES-1:0] rise_next;

    // ------------------------------------------------------------
    // edge detect
    // ------------------------------------------------------------
    // only the second stage feeds the detector
    always_comb
    begin
        rise_next = sync_reg & ~prev_reg;
    end

    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            meta_reg <= '0;
            sync_reg <= '0;
            prev_reg <= '0;
            rise_reg <= '0;
        end
        else
        begin
            meta_reg <= lanes.raw;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
            rise_reg <= rise_next;
        end
    end

    assign lanes.rise = rise_reg;
endmodule : fcr_edge_sync

// File: core/fcr_freq_counter.sv
// clock ratio frequency counter with crystal oscillator control bits
// assumes an 8-bit register port on the system clock; clock pins are
// sampled, so measured clocks must stay below a quarter of i_clock
`timescale 1ns/1ps
module fcr_freq_counter (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic [15:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    input wire logic i_ref_clock_pin,
    input wire logic i_osc24_clock,
    input wire logic i_crystal_interval_clock,
    input wire logic i_sleep_timer_clock,
    input wire logic i_lc_oscillator,
    input wire logic i_divider_clock,
    output logic o_count_finished_irq,
    output logic o_crystal_osc_enable,
    output logic o_small_load_select
);
    fcr_edge_if edges ();

    logic [fcr_pkg::MODE_W-1:0] mode_reg, mode_next;
    logic clksel_reg, clksel_next;
    logic busy_reg, busy_next;
    logic done_reg, done_next;
    logic [fcr_pkg::INTERVAL_W-1:0] interval_reg, interval_next;
    logic [1:0] xo_reg, xo_next;
    fcr_pkg::fcr_state_e state_reg, state_next;
    logic [1:0] dly_reg, dly_next;
    logic [fcr_pkg::REMAIN_W-1:0] remain_reg, remain_next;
    logic [fcr_pkg::TALLY_W-1:0] tally_reg, tally_next;
    logic [7:0] rdata_next;
    logic ctrl_wr, trig, int_rise, meas_rise, finish;
    logic [fcr_pkg::MODE_W-1:0] wmode;

    assign edges.raw = {i_divider_clock, i_lc_oscillator,
                        i_sleep_timer_clock, i_crystal_interval_clock,
                        i_osc24_clock, i_ref_clock_pin};

    fcr_edge_sync i_fcr_edge_sync (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .lanes(edges)
    );

    // ------------------------------------------------------------
    // source selection
    // ------------------------------------------------------------
    always_comb
    begin
        case (mode_reg)
            fcr_pkg::MODE_REF: int_rise = edges.rise[fcr_pkg::LANE_REF];
            fcr_pkg::MODE_OSC24: int_rise = edges.rise[fcr_pkg::LANE_OSC24];
            // the system clock rises on every cycle
            fcr_pkg::MODE_SYSCLK: int_rise = 1'b1;
            fcr_pkg::MODE_XTAL: int_rise = edges.rise[fcr_pkg::LANE_XTAL];
            fcr_pkg::MODE_SLEEP: int_rise = edges.rise[fcr_pkg::LANE_SLEEP];
            default: int_rise = 1'b0;
        endcase
        meas_rise = clksel_reg ? edges.rise[fcr_pkg::LANE_DIV]
                               : edges.rise[fcr_pkg::LANE_LC];
    end

    // ------------------------------------------------------------
    // control state
    // ------------------------------------------------------------
    always_comb
    begin
        ctrl_wr = i_reg_wr && (i_reg_addr == fcr_pkg::ADDR_FC_CTRL);
        wmode = i_reg_wdata[fcr_pkg::MODE_W-1:0];
        mode_next = ctrl_wr ? wmode : mode_reg;
        clksel_next = ctrl_wr ? i_reg_wdata[fcr_pkg::BIT_CLKSEL]
                              : clksel_reg;
        trig = ctrl_wr && i_reg_wdata[fcr_pkg::BIT_BUSY]
               && (wmode != fcr_pkg::MODE_OFF);
        interval_next = interval_reg;
        if (i_reg_wr && (i_reg_addr == fcr_pkg::ADDR_INTERVAL_LENGTH_CODE))
            interval_next = i_reg_wdata[fcr_pkg::INTERVAL_W-1:0];
        xo_next = xo_reg;
        if (i_reg_wr && (i_reg_addr == fcr_pkg::ADDR_XO_CTRL))
            xo_next = i_reg_wdata[1:0];
        finish = (state_reg == fcr_pkg::ST_RUN) && int_rise
                 && (remain_reg == {{(fcr_pkg::REMAIN_W-1){1'b0}}, 1'b1});
        state_next = state_reg;
        dly_next = dly_reg;
        remain_next = remain_reg;
        tally_next = tally_reg;
        busy_next = busy_reg;
        // any value may be written, so a one raises the request
        done_next = ctrl_wr ? i_reg_wdata[fcr_pkg::BIT_DONE]
                            : done_reg;
        case (state_reg)
            fcr_pkg::ST_SYNC:
            begin
                if (dly_reg == 2'h0)
                    state_next = fcr_pkg::ST_ARM;
                else
                    dly_next = dly_reg - 2'h1;
            end
            fcr_pkg::ST_ARM:
            begin
                if (int_rise)
                begin
                    state_next = fcr_pkg::ST_RUN;
                    remain_next = fcr_pkg::window_len(interval_reg);
                end
            end
            fcr_pkg::ST_RUN:
            begin
                if (meas_rise)
                    tally_next = tally_reg + 23'h000001;
                if (finish)
                begin
                    state_next = fcr_pkg::ST_DONE_DLY;
                    busy_next = 1'b0;
                    dly_next = fcr_pkg::DONE_DLY;
                end
                else if (int_rise)
                    remain_next = remain_reg - 24'h000001;
            end
            fcr_pkg::ST_DONE_DLY:
            begin
                if (dly_reg == 2'h0)
                begin
                    state_next = fcr_pkg::ST_IDLE;
                    done_next = 1'b1;
                end
                else
                    dly_next = dly_reg - 2'h1;
            end
            fcr_pkg::ST_OFF:
            begin
                if (mode_reg != fcr_pkg::MODE_OFF)
                    state_next = fcr_pkg::ST_IDLE;
            end
            default: state_next = state_reg;
        endcase
        if (trig)
        begin
            state_next = fcr_pkg::ST_SYNC;
            dly_next = fcr_pkg::TRIG_DLY;
            tally_next = '0;
            busy_next = 1'b1;
            // the hardware set of a finishing count still wins
            if (!(state_reg == fcr_pkg::ST_DONE_DLY && dly_reg == 2'h0))
                done_next = 1'b0;
        end
        if (ctrl_wr && wmode == fcr_pkg::MODE_OFF)
        begin
            state_next = fcr_pkg::ST_OFF;
            busy_next = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // read path, tally big endian with high bits zero
    // ------------------------------------------------------------
    always_comb
    begin
        case (i_reg_addr)
            fcr_pkg::ADDR_FC_CTRL:
                rdata_next = {done_reg, busy_reg, clksel_reg, 2'h0, mode_reg};
            fcr_pkg::ADDR_INTERVAL_LENGTH_CODE: rdata_next = {2'h0, interval_reg};
            fcr_pkg::ADDR_TALLY_B3: rdata_next = 8'h00;
            fcr_pkg::ADDR_TALLY_B2: rdata_next = {1'b0, tally_reg[22:16]};
            fcr_pkg::ADDR_TALLY_B1: rdata_next = tally_reg[15:8];
            fcr_pkg::ADDR_TALLY_B0: rdata_next = tally_reg[7:0];
            fcr_pkg::ADDR_XO_CTRL: rdata_next = {6'h00, xo_reg};
            default: rdata_next = fcr_pkg::RST_BYTE;
        endcase
    end

    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            mode_reg <= fcr_pkg::RST_MODE;
            clksel_reg <= 1'b0;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
            interval_reg <= fcr_pkg::RST_INTERVAL;
            xo_reg <= 2'h0;
            state_reg <= fcr_pkg::ST_OFF;
            dly_reg <= 2'h0;
            remain_reg <= '0;
            tally_reg <= '0;
            o_reg_rdata <= fcr_pkg::RST_BYTE;
            o_count_finished_irq <= 1'b0;
            o_crystal_osc_enable <= 1'b0;
            o_small_load_select <= 1'b0;
        end
        else
        begin
            mode_reg <= mode_next;
            clksel_reg <= clksel_next;
            busy_reg <= busy_next;
            done_reg <= done_next;
            interval_reg <= interval_next;
            xo_reg <= xo_next;
            state_reg <= state_next;
            dly_reg <= dly_next;
            remain_reg <= remain_next;
            tally_reg <= tally_next;
            o_reg_rdata <= rdata_next;
            o_count_finished_irq <= done_next;
            o_crystal_osc_enable <= xo_next[fcr_pkg::BIT_CRYSTAL_OSC_ENABLE];
            o_small_load_select <= xo_next[fcr_pkg::BIT_LOWCAP];
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_off_stopped: assert property (
        @(posedge i_clock) disable iff (i_rst)
        (mode_reg == fcr_pkg::MODE_OFF) |->
            (!busy_reg && state_reg == fcr_pkg::ST_OFF))
        else $error("disabled counter not stopped");
    chk_retrig_reset: assert property (
        @(posedge i_clock) disable iff (i_rst)
        trig |=> (tally_reg == '0 && busy_reg
                  && state_reg == fcr_pkg::ST_SYNC))
        else $error("trigger did not reset and rearm");
    chk_arm_waits: assert property (
        @(posedge i_clock) disable iff (i_rst)
        (state_reg == fcr_pkg::ST_ARM && !int_rise && !ctrl_wr)
            |=> (state_reg == fcr_pkg::ST_ARM && $stable(tally_reg)))
        else $error("counting began before interval edge");
    chk_window_load: assert property (
        @(posedge i_clock) disable iff (i_rst)
        (state_reg == fcr_pkg::ST_ARM && int_rise && !ctrl_wr) |=>
            remain_reg == fcr_pkg::window_len($past(interval_reg)))
        else $error("window length wrong");
    chk_done_delay: assert property (
        @(posedge i_clock) disable iff (i_rst)
        finish && !ctrl_wr ##1 (!ctrl_wr)[*3] |=>
            (done_reg && !busy_reg && state_reg == fcr_pkg::ST_IDLE))
        else $error("finished flag not set after delay");
    chk_tally_hold: assert property (
        @(posedge i_clock) disable iff (i_rst)
        (state_reg != fcr_pkg::ST_RUN && !trig) |=> $stable(tally_reg))
        else $error("tally moved while stopped");
    chk_tally_step: assert property (
        @(posedge i_clock) disable iff (i_rst)
        (state_reg == fcr_pkg::ST_RUN && meas_rise && !trig) |=>
            tally_reg == $past(tally_reg) + 23'h000001)
        else $error("tally did not step");
    chk_high_zero: assert property (
        @(posedge i_clock) disable iff (i_rst)
        (i_reg_addr == fcr_pkg::ADDR_TALLY_B3) |=> o_reg_rdata == 8'h00)
        else $error("upper tally byte not zero");
    chk_live_read: assert property (
        @(posedge i_clock) disable iff (i_rst)
        (i_reg_addr == fcr_pkg::ADDR_TALLY_B0) |=>
            o_reg_rdata == $past(tally_reg[7:0]))
        else $error("tally read not live");
    chk_xo_enable: assert property (
        @(posedge i_clock) disable iff (i_rst)
        (i_reg_wr && i_reg_addr == fcr_pkg::ADDR_XO_CTRL) |=>
            o_crystal_osc_enable == $past(i_reg_wdata[0]))
        else $error("crystal enable not applied");
    chk_irq_level: assert property (
        @(posedge i_clock) disable iff (i_rst)
        ctrl_wr && i_reg_wdata[fcr_pkg::BIT_DONE] && !trig |=>
            o_count_finished_irq && done_reg)
        else $error("written finished flag did not raise request");
endmodule : fcr_freq_counter

// File: inc/fcr_edge_if.sv
// carries raw clock pins into the synchroniser and rising edges back
// assumes both ends run on the system clock
`timescale 1ns/1ps
interface fcr_edge_if;
    logic [fcr_pkg::LANES-1:0] raw;
    logic [fcr_pkg::LANES-1:0] rise;
    modport sync (input raw, output rise);
    modport user (output raw, input rise);
endinterface : fcr_edge_if

// File: inc/fcr_pkg.sv
// constants, register map and types of the clock ratio frequency counter
// assumes one 8-bit special-function register port on the system clock
package fcr_pkg;

    // ------------------------------------------------------------
    // register addresses
    // ------------------------------------------------------------
    localparam logic [15:0] ADDR_FC_CTRL = 16'h009B;
    localparam logic [15:0] ADDR_INTERVAL_LENGTH_CODE = 16'h009D;
    localparam logic [15:0] ADDR_TALLY_B3 = 16'h4008;
    localparam logic [15:0] ADDR_TALLY_B2 = 16'h4009;
    localparam logic [15:0] ADDR_TALLY_B1 = 16'h400A;
    localparam logic [15:0] ADDR_TALLY_B0 = 16'h400B;
    localparam logic [15:0] ADDR_XO_CTRL = 16'h4016;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int BIT_DONE = 7;
    localparam int BIT_BUSY = 6;
    localparam int BIT_CLKSEL = 5;
    localparam int BIT_LOWCAP = 1;
    localparam int BIT_CRYSTAL_OSC_ENABLE = 0;
    localparam int MODE_W = 3;
    localparam int INTERVAL_W = 6;
    localparam int TALLY_W = 23;
    localparam int REMAIN_W = 24;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [MODE_W-1:0] RST_MODE = 3'h0;
    localparam logic [INTERVAL_W-1:0] RST_INTERVAL = 6'h00;
    localparam logic [5:0] INTERVAL_MAX = 6'h2B;

    // ------------------------------------------------------------
    // source mode codes
    // ------------------------------------------------------------
    localparam logic [MODE_W-1:0] MODE_OFF = 3'h0;
    localparam logic [MODE_W-1:0] MODE_REF = 3'h1;
    localparam logic [MODE_W-1:0] MODE_OSC24 = 3'h2;
    localparam logic [MODE_W-1:0] MODE_SYSCLK = 3'h3;
    localparam logic [MODE_W-1:0] MODE_XTAL = 3'h4;
    localparam logic [MODE_W-1:0] MODE_SLEEP = 3'h6;

    // ------------------------------------------------------------
    // edge lanes and synchronisation delays
    // ------------------------------------------------------------
    localparam int LANES = 6;
    localparam int LANE_REF = 0;
    localparam int LANE_OSC24 = 1;
    localparam int LANE_XTAL = 2;
    localparam int LANE_SLEEP = 3;
    localparam int LANE_LC = 4;
    localparam int LANE_DIV = 5;
    localparam logic [1:0] TRIG_DLY = 2'h3;
    localparam logic [1:0] DONE_DLY = 2'h2;

    typedef enum logic [2:0] {
        ST_OFF,
        ST_IDLE,
        ST_SYNC,
        ST_ARM,
        ST_RUN,
        ST_DONE_DLY
    } fcr_state_e;

    // window length in interval clock cycles
    function automatic logic [REMAIN_W-1:0] window_len(
        input logic [INTERVAL_W-1:0] code);
        logic [REMAIN_W-1:0] base;
        base = {{(REMAIN_W-2){1'b0}}, 1'b1, code[0]};
        if (code > INTERVAL_MAX)
            window_len = {{(REMAIN_W-1){1'b0}}, 1'b1};
        else
            window_len = base << code[5:1];
    endfunction : window_len

endpackage : fcr_pkg

// File: verif/fcr_freq_counter_tb.sv
// self-checking bench of the clock ratio frequency counter
// assumes fcr_pkg, the edge interface and the core are compiled first
`timescale 1ns/1ps
module fcr_freq_counter_tb;
    // ------------------------------------------------------------
    // signals and bookkeeping
    // ------------------------------------------------------------
    logic i_clock;
    logic i_rst;
    logic [15:0] i_reg_addr;
    logic i_reg_wr;
    logic [7:0] i_reg_wdata;
    logic [7:0] o_reg_rdata;
    logic [3:0] pin;
    logic lc;
    logic dv;
    logic o_count_finished_irq;
    logic o_crystal_osc_enable;
    logic o_small_load_select;
    logic look;
    logic look_d;
    logic [7:0] exp_q[$];
    logic [31:0] lfsr;
    logic [2:0] modes[4];
    int num_errors;
    int checks;
    int cyc;
    // interval pins rise 3 cycles after a measured edge, so counts are exact
    int per[4];

    fcr_freq_counter i_fcr_freq_counter (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_reg_addr(i_reg_addr),
        .i_reg_wr(i_reg_wr),
        .i_reg_wdata(i_reg_wdata),
        .o_reg_rdata(o_reg_rdata),
        .i_ref_clock_pin(pin[0]),
        .i_osc24_clock(pin[1]),
        .i_crystal_interval_clock(pin[2]),
        .i_sleep_timer_clock(pin[3]),
        .i_lc_oscillator(lc),
        .i_divider_clock(dv),
        .o_count_finished_irq(o_count_finished_irq),
        .o_crystal_osc_enable(o_crystal_osc_enable),
        .o_small_load_select(o_small_load_select)
    );

    initial
    begin
        i_clock = 1'b0;
        forever #25 i_clock = ~i_clock;
    end

    // ------------------------------------------------------------
    // source clocks, timeout and result monitor
    // ------------------------------------------------------------
    always @(posedge i_clock)
    begin
        cyc <= cyc + 1;
        for (int k = 0; k < 4; k++)
            pin[k] <= ((cyc + per[k] - 3) % per[k]) < per[k] / 2;
        lc <= (cyc % 6) < 3;
        dv <= (cyc % 12) < 6;
        if (cyc == 40000)
        begin
            num_errors++;
            wrap_up();
        end
    end

    always @(posedge i_clock)
    begin
        look_d <= look;
        if (look_d === 1'b1 && exp_q.size() > 0)
            check(o_reg_rdata, exp_q.pop_front());
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        checks++;
        if (seen !== want)
        begin
            num_errors++;
            $display("wrong value at %0t: got %h want %h", $time, seen, want);
        end
    endtask : check

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : wrap_up

    function automatic logic [31:0] step(input logic [31:0] s);
        step = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : step

    function automatic int wl(input logic [5:0] code);
        wl = (code > 43) ? 1 : (2 + code[0]) << code[5:1];
    endfunction : wl

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge i_clock);
        i_reg_addr <= a;
        i_reg_wdata <= d;
        i_reg_wr <= 1'b1;
        @(posedge i_clock);
        i_reg_wr <= 1'b0;
    endtask : wr

    // notes the expected byte; the monitor compares it two cycles later
    task automatic rd(input logic [15:0] a, input logic [7:0] want);
        @(posedge i_clock);
        i_reg_addr <= a;
        look <= 1'b1;
        exp_q.push_back(want);
        @(posedge i_clock);
        look <= 1'b0;
    endtask : rd

    task automatic rd_tally(input logic [22:0] v);
        rd(fcr_pkg::ADDR_TALLY_B3, 8'h00);
        rd(fcr_pkg::ADDR_TALLY_B2, {1'b0, v[22:16]});
        rd(fcr_pkg::ADDR_TALLY_B1, v[15:8]);
        rd(fcr_pkg::ADDR_TALLY_B0, v[7:0]);
    endtask : rd_tally

    task automatic run(input logic [2:0] m, input logic [5:0] code,
        input logic sel, input int cnt);
        int n;
        n = 0;
        wr(fcr_pkg::ADDR_INTERVAL_LENGTH_CODE, {2'b00, code});
        wr(fcr_pkg::ADDR_FC_CTRL, {2'b01, sel, 2'b00, m});
        repeat (2) @(posedge i_clock);
        check({7'h00, o_count_finished_irq}, 8'h00);
        while (o_count_finished_irq !== 1'b1 && n < 5000)
        begin
            @(posedge i_clock);
            n++;
        end
        check({7'h00, o_count_finished_irq}, 8'h01);
        rd(fcr_pkg::ADDR_FC_CTRL, {2'b10, sel, 2'b00, m});
        if (cnt >= 0)
            rd_tally(cnt[22:0]);
    endtask : run

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        per = '{60, 120, 180, 240};
        modes = '{fcr_pkg::MODE_REF, fcr_pkg::MODE_OSC24,
            fcr_pkg::MODE_XTAL, fcr_pkg::MODE_SLEEP};
        i_rst = 1'b1;
        i_reg_addr = 16'h0000;
        i_reg_wr = 1'b0;
        i_reg_wdata = 8'h00;
        pin = 4'h0;
        lc = 1'b0;
        dv = 1'b0;
        look = 1'b0;
        look_d = 1'b0;
        lfsr = 32'hc75f7225;
        num_errors = 0;
        checks = 0;
        cyc = 0;
        repeat (20) @(posedge i_clock);
        i_rst <= 1'b0;
        rd(fcr_pkg::ADDR_FC_CTRL, 8'h00);
        rd(fcr_pkg::ADDR_INTERVAL_LENGTH_CODE, 8'h00);
        rd(fcr_pkg::ADDR_XO_CTRL, 8'h00);
        rd(16'h1234, 8'h00);
        wr(fcr_pkg::ADDR_INTERVAL_LENGTH_CODE, 8'hFF);
        rd(fcr_pkg::ADDR_INTERVAL_LENGTH_CODE, 8'h3F);
        wr(fcr_pkg::ADDR_FC_CTRL, 8'h18);
        rd(fcr_pkg::ADDR_FC_CTRL, 8'h00);
        $display("test register reset done");
        wr(fcr_pkg::ADDR_FC_CTRL, 8'h01);
        repeat (300) @(posedge i_clock);
        rd(fcr_pkg::ADDR_FC_CTRL, 8'h01);
        rd_tally(23'h000000);
        $display("test idle done");
        for (int j = 0; j < 2; j++)
            for (int k = 0; k < 4; k++)
            begin
                lfsr = step(lfsr);
                run(modes[k], {4'h0, lfsr[2:1]}, lfsr[0] ^ j[0],
                    wl({4'h0, lfsr[2:1]}) * per[k] / ((lfsr[0] ^ j[0]) ? 12 : 6));
            end
        run(fcr_pkg::MODE_SYSCLK, 6'h00, 1'b0, -1);
        run(fcr_pkg::MODE_REF, 6'd44, 1'b0, 10);
        $display("test sources done");
        // a long window, so the retrigger lands in the middle of a count
        wr(fcr_pkg::ADDR_INTERVAL_LENGTH_CODE, 8'h04);
        wr(fcr_pkg::ADDR_FC_CTRL, 8'h41);
        repeat (150) @(posedge i_clock);
        rd(fcr_pkg::ADDR_FC_CTRL, 8'h41);
        run(fcr_pkg::MODE_REF, 6'h02, 1'b0, 40);
        repeat (200) @(posedge i_clock);
        rd_tally(23'd40);
        $display("test restart done");
        for (int k = 5; k < 8; k += 2)
        begin
            wr(fcr_pkg::ADDR_FC_CTRL, {5'b01000, k[2:0]});
            repeat (100) @(posedge i_clock);
            rd(fcr_pkg::ADDR_FC_CTRL, {5'b01000, k[2:0]});
            wr(fcr_pkg::ADDR_FC_CTRL, 8'h00);
            rd(fcr_pkg::ADDR_FC_CTRL, 8'h00);
            run(fcr_pkg::MODE_REF, 6'h00, 1'b0, 20);
        end
        $display("test disable done");
        // software clears the flag after the tally of the last run was read
        wr(fcr_pkg::ADDR_FC_CTRL, 8'h00);
        @(posedge i_clock);
        check({7'h00, o_count_finished_irq}, 8'h00);
        wr(fcr_pkg::ADDR_FC_CTRL, 8'h80);
        rd(fcr_pkg::ADDR_FC_CTRL, 8'h80);
        check({7'h00, o_count_finished_irq}, 8'h01);
        $display("test flag write done");
        // bench takes the bandgap as already up before the crystal is used
        wr(fcr_pkg::ADDR_XO_CTRL, 8'hFF);
        rd(fcr_pkg::ADDR_XO_CTRL, 8'h03);
        check({6'h00, o_small_load_select, o_crystal_osc_enable}, 8'h03);
        wr(fcr_pkg::ADDR_XO_CTRL, 8'h02);
        rd(fcr_pkg::ADDR_XO_CTRL, 8'h02);
        check({6'h00, o_small_load_select, o_crystal_osc_enable}, 8'h02);
        $display("test crystal control done");
        repeat (3) @(posedge i_clock);
        wrap_up();
    end
endmodule : fcr_freq_counter_tb
